// ### core/twisted_pair_status_mode_ctl.sv
// Contract
// (R1) Self test pulses collision status after each frame
// (R2) Over 20 ms transmit enters jabber, disables paths
// (R3) Jabber drives collision and jabber status high
// (R4) Jabber ends after 500 ms quiet or idle
// (R5) Jabber status stays low through reset
// (R6) Low full-duplex select makes paths independent
// (R7) Full duplex hides collisions, keeps self test
// (R8) Collision alone or both high for jabber
// (R9) Link status low on link failure
// (R10) Link high on pulses, toggling on data
// (R11) Link toggles every 100 ms during data
// (R12) Normal mode loops transmit when receiver idle
// (R13) Loop test loops internally, ignores receiver
// (R14) Normal select: transmit plus receive means collision
// (R15) Self test window leaves data paths undisturbed
// (R16) Full-duplex high: loopback works, collisions shown
// (R17) Collision status held through collision and after
// (R18) Loopback off on collision or full duplex
// (R19) Hold and self-test windows are cycle parameters
`timescale 1ns/1ps
`default_nettype none
module twisted_pair_status_mode_ctl #(
    parameter int unsigned JAB_TRIP   = tp_status_pkg::JAB_TRIP_CYC,
    parameter int unsigned JAB_QUIET  = tp_status_pkg::JAB_QUIET_CYC,
    parameter int unsigned LINK_TOG   = tp_status_pkg::LINK_TOG_CYC,
    parameter int unsigned COLL_HOLD  = tp_status_pkg::COLL_HOLD_CYC,
    parameter int unsigned SQE_WIN    = tp_status_pkg::SQE_WIN_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tx_en,
    input  wire logic tx_data,
    input  wire logic rx_unsquelch,
    input  wire logic rx_data,
    input  wire logic link_fail,
    input  wire logic loop_sel_n,
    input  wire logic collision_selftest_sel_n,
    input  wire logic full_duplex_sel_n,
    output var  logic driver_en,
    output var  logic tx_line_data,
    output var  logic rx_en_out,
    output var  logic rx_data_out,
    output var  logic collision_status,
    output var  logic jabber_status,
    output var  logic link_status,
    output var  logic full_duplex_active
);
    import tp_status_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              tx_en_d_r;
    logic              tx_data_d_r;
    logic              tx_en_s;
    logic              tx_data_s;
    logic              rx_unsq_s;
    logic              rx_data_s;
    logic              link_fail_s;
    logic              loop_test;
    logic              sqe_en;
    logic              fd;
    logic              tx_fell;
    logic              jabber;
    logic              coll_raw;
    logic              coll_active;
    logic              announce;
    logic              sqe_active;
    logic              loop_normal;
    logic              loop_int;
    logic              loop_on;
    logic              rx_active;
    logic [CNT_W-1:0]  hold_cnt_r;
    logic [CNT_W-1:0]  sqe_cnt_r;
    logic [CNT_W-1:0]  tog_cnt_r;
    link_state_e       link_state_r;

    jab_if jb ();

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // All pins come from outside the clock domain; stage one is read
    // only by stage two.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= {full_duplex_sel_n, collision_selftest_sel_n,
                        loop_sel_n, link_fail, rx_data, rx_unsquelch,
                        tx_data, tx_en};
            sync2_r <= sync1_r;
        end
    end

    assign tx_en_s     = sync2_r[PIN_TX_EN];
    assign tx_data_s   = sync2_r[PIN_TX_DATA];
    assign rx_unsq_s   = sync2_r[PIN_RX_UNSQ];
    assign rx_data_s   = sync2_r[PIN_RX_DATA];
    assign link_fail_s = sync2_r[PIN_LINK_FAIL];
    assign loop_test   = !sync2_r[PIN_LOOP_N];
    // Self test taken as enabled by the low level of its select
    assign sqe_en      = !sync2_r[PIN_SQE_N];
    assign fd          = !sync2_r[PIN_FD_N]; // R6

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_en_d_r   <= 1'b0;
            tx_data_d_r <= 1'b0;
        end else begin
            tx_en_d_r   <= tx_en_s;
            tx_data_d_r <= tx_data_s;
        end
    end

    assign tx_fell = tx_en_d_r && !tx_en_s;

    // ----------------------------------------------------------------
    // Jabber watchdog
    // ----------------------------------------------------------------
    assign jb.tx_en   = tx_en_s;
    assign jb.tx_edge = tx_data_s ^ tx_data_d_r;
    assign jabber     = jb.jabber;

    jabber_watchdog #(
        .TRIP_CYC  (JAB_TRIP),
        .QUIET_CYC (JAB_QUIET)
    ) u_jab (
        .clk   (clk),
        .rst_n (rst_n),
        .jb    (jb.wd)
    );

    // ----------------------------------------------------------------
    // Collision detect and self test
    // ----------------------------------------------------------------
    // Loop test never unsquelches and jabber disables the detector
    assign coll_raw    = tx_en_s && rx_unsq_s && !loop_test
                         && !jabber; // R14 R13 R2
    assign coll_active = coll_raw || (hold_cnt_r != '0);
    assign announce    = coll_active && !fd; // R7 R16
    assign sqe_active  = (sqe_cnt_r != '0);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_cnt_r <= '0;
        end else if (coll_raw) begin
            hold_cnt_r <= CNT_W'(COLL_HOLD); // R17 R19
        end else if (hold_cnt_r != '0) begin
            hold_cnt_r <= hold_cnt_r - 1'b1;
        end
    end

    // Self test only drives status; the data paths never see it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sqe_cnt_r <= '0;
        end else if (sqe_en && tx_fell && !jabber) begin
            sqe_cnt_r <= CNT_W'(SQE_WIN); // R1 R15 R19
        end else if (sqe_cnt_r != '0) begin
            sqe_cnt_r <= sqe_cnt_r - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            collision_status   <= 1'b0;
            jabber_status      <= 1'b0; // R5
            full_duplex_active <= 1'b0;
        end else begin
            collision_status   <= jabber || announce || sqe_active; // R3 R8
            jabber_status      <= jabber; // R3 R8
            full_duplex_active <= fd;
        end
    end

    // ----------------------------------------------------------------
    // Data paths and loopback
    // ----------------------------------------------------------------
    assign loop_normal = !loop_test && tx_en_s && !rx_unsq_s
                         && !coll_active && !fd && !jabber; // R12 R18
    assign loop_int    = loop_test && !fd && !jabber; // R13 R18 R2
    assign loop_on     = loop_normal || loop_int;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            driver_en    <= 1'b0;
            tx_line_data <= 1'b0;
        end else begin
            driver_en    <= tx_en_s && !jabber; // R2
            tx_line_data <= tx_data_s && tx_en_s && !jabber;
        end
    end

    // In full duplex the receive side follows the line only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_en_out   <= 1'b0;
            rx_data_out <= 1'b0;
        end else if (loop_on) begin
            rx_en_out   <= tx_en_s; // R12 R13
            rx_data_out <= tx_data_s;
        end else begin
            rx_en_out   <= rx_unsq_s && !loop_test; // R6
            rx_data_out <= rx_unsq_s && !loop_test && rx_data_s;
        end
    end

    // ----------------------------------------------------------------
    // Link integrity status
    // ----------------------------------------------------------------
    assign rx_active = rx_unsq_s && !loop_test;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_state_r <= LNK_PULSE;
            link_status  <= 1'b1;
            tog_cnt_r    <= '0;
        end else begin
            case (link_state_r)
                LNK_FAIL, LNK_PULSE: begin
                    tog_cnt_r <= '0;
                    if (link_fail_s) begin
                        link_state_r <= LNK_FAIL;
                        link_status  <= 1'b0; // R9
                    end else if (rx_active) begin
                        link_state_r <= LNK_DATA;
                        link_status  <= 1'b1;
                    end else begin
                        link_state_r <= LNK_PULSE;
                        link_status  <= 1'b1; // R10
                    end
                end
                LNK_DATA: begin
                    if (link_fail_s) begin
                        link_state_r <= LNK_FAIL;
                        link_status  <= 1'b0; // R9
                        tog_cnt_r    <= '0;
                    end else if (!rx_active) begin
                        link_state_r <= LNK_PULSE;
                        link_status  <= 1'b1;
                        tog_cnt_r    <= '0;
                    end else if (tog_cnt_r == CNT_W'(LINK_TOG - 1)) begin
                        link_status  <= !link_status; // R10 R11
                        tog_cnt_r    <= '0;
                    end else begin
                        tog_cnt_r    <= tog_cnt_r + 1'b1;
                    end
                end
                default: begin
                    link_state_r <= LNK_FAIL;
                    link_status  <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence frame_end;
        sqe_en && tx_fell && !jabber;
    endsequence

    sequence tx_only;
        loop_normal;
    endsequence

    sequence coll_seen;
        coll_raw && !fd;
    endsequence

    a_jab_both_high: assert property (
        jabber_status |-> collision_status)
        else $error("jabber without collision status"); // R3

    a_jab_drv_off: assert property (
        jabber |=> !driver_en && !tx_line_data && jabber_status)
        else $error("driver active in jabber"); // R2

    // Watch the registered receive enable so a broken loop gate shows
    a_jab_no_loop: assert property (
        (jabber |-> !coll_raw) and (jabber && !rx_unsq_s |=> !rx_en_out))
        else $error("loopback or collision alive in jabber"); // R2

    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n |=> !jabber_status)
        else $error("jabber status set after reset"); // R5

    a_sqe_window: assert property (
        frame_end |-> ##2 collision_status[*2])
        else $error("self test pulse missing"); // R1

    a_coll_shown: assert property (
        coll_seen |=> collision_status)
        else $error("collision not announced"); // R17

    a_fd_quiet: assert property (
        fd && !sqe_active && !jabber |=> !collision_status)
        else $error("collision shown in full duplex"); // R7

    a_fd_no_loop: assert property (
        fd |-> !loop_on)
        else $error("loopback in full duplex"); // R18

    a_loop_normal: assert property (
        tx_only |=> rx_en_out && rx_data_out == $past(tx_data_s))
        else $error("normal loopback data wrong"); // R12

    a_loop_test: assert property (
        loop_int |=> rx_en_out == $past(tx_en_s)
                     && rx_data_out == $past(tx_data_s))
        else $error("loop test path wrong"); // R13

    a_link_fail: assert property (
        link_fail_s |=> !link_status)
        else $error("link failure not reported"); // R9

    a_link_pulse: assert property (
        !link_fail_s && !rx_active |=> link_status)
        else $error("link not high on pulses"); // R10

endmodule
`default_nettype wire

// ### core/tp_status_pkg.sv
package tp_status_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned JAB_TRIP_MS    = 20;
    localparam int unsigned JAB_TRIP_CYC   = JAB_TRIP_MS * CYC_PER_MS;
    localparam int unsigned JAB_QUIET_MS   = 500;
    localparam int unsigned JAB_QUIET_CYC  = JAB_QUIET_MS * CYC_PER_MS;
    localparam int unsigned LINK_TOG_MS    = 100;
    localparam int unsigned LINK_TOG_CYC   = LINK_TOG_MS * CYC_PER_MS;
    localparam int unsigned COLL_HOLD_CYC  = 25;
    localparam int unsigned SQE_WIN_CYC    = 25;
    localparam int unsigned CNT_W          = 32;

    // ----------------------------------------------------------------
    // Synchroniser bit positions and reset value
    // ----------------------------------------------------------------
    localparam int unsigned SYNC_W         = 8;
    localparam int unsigned PIN_TX_EN      = 0;
    localparam int unsigned PIN_TX_DATA    = 1;
    localparam int unsigned PIN_RX_UNSQ    = 2;
    localparam int unsigned PIN_RX_DATA    = 3;
    localparam int unsigned PIN_LINK_FAIL  = 4;
    localparam int unsigned PIN_LOOP_N     = 5;
    localparam int unsigned PIN_SQE_N      = 6;
    localparam int unsigned PIN_FD_N       = 7;
    // Active-low mode pins rest high so reset selects normal mode
    localparam logic [SYNC_W-1:0] SYNC_RST = 8'hE0;

    typedef enum logic [1:0] {LNK_FAIL, LNK_PULSE, LNK_DATA} link_state_e;
    typedef enum logic {JAB_OK, JAB_ON} jab_state_e;

endpackage

// ### core/jab_if.sv
`timescale 1ns/1ps
`default_nettype none
interface jab_if;
    logic tx_en;
    logic tx_edge;
    logic jabber;

    modport ctl (output tx_en, output tx_edge, input jabber);
    modport wd  (input tx_en, input tx_edge, output jabber);
endinterface
`default_nettype wire

// ### core/jabber_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module jabber_watchdog #(
    parameter int unsigned TRIP_CYC  = tp_status_pkg::JAB_TRIP_CYC,
    parameter int unsigned QUIET_CYC = tp_status_pkg::JAB_QUIET_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    jab_if.wd         jb
);
    import tp_status_pkg::*;

    jab_state_e        state_r;
    logic [CNT_W-1:0]  act_cnt_r;
    logic [CNT_W-1:0]  quiet_cnt_r;
    logic              quiet;

    // Quiet means enable low, or no data edge in this cycle
    assign quiet     = !jb.tx_en || !jb.tx_edge;
    assign jb.jabber = (state_r == JAB_ON);

    // ----------------------------------------------------------------
    // Trip and release
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r     <= JAB_OK;
            act_cnt_r   <= '0;
            quiet_cnt_r <= '0;
        end else begin
            case (state_r)
                JAB_OK: begin
                    quiet_cnt_r <= '0;
                    if (!jb.tx_en) begin
                        act_cnt_r <= '0;
                    end else if (act_cnt_r == CNT_W'(TRIP_CYC - 1)) begin
                        act_cnt_r <= '0;
                        state_r   <= JAB_ON; // R2
                    end else begin
                        act_cnt_r <= act_cnt_r + 1'b1;
                    end
                end
                JAB_ON: begin
                    act_cnt_r <= '0;
                    // A toggle while enable is high restarts the quiet run
                    if (!quiet) begin
                        quiet_cnt_r <= '0;
                    end else if (quiet_cnt_r == CNT_W'(QUIET_CYC - 1)) begin
                        quiet_cnt_r <= '0;
                        state_r     <= JAB_OK; // R4
                    end else begin
                        quiet_cnt_r <= quiet_cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= JAB_OK;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### tb/mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic send,
    input  wire logic toggle,
    output var  logic tx_en,
    output var  logic tx_data
);
    // ----------------------------------------------------------------
    // Transmit side of the controller
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_en   <= 1'b0;
            tx_data <= 1'b0;
        end else begin
            tx_en <= send;
            // Data held still while enabled is the quiet that ends jabber
            if (send && toggle) begin
                tx_data <= ~tx_data;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/test_twisted_pair_status_mode_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module test_twisted_pair_status_mode_ctl;
    import tp_status_pkg::*;
    // ----------------------------------------------------------------
    // Shortened counts keep the run small
    // ----------------------------------------------------------------
    localparam int TRIP = 40;
    localparam int QUIET = 60;
    localparam int TOG = 20;
    localparam int HOLD = 5;
    localparam int WIN = 4;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic send = 1'b0;
    logic toggle = 1'b0;
    logic tx_en;
    logic tx_data;
    logic rx_unsquelch = 1'b0;
    logic rx_data = 1'b0;
    logic link_fail = 1'b0;
    logic loop_sel_n = 1'b1;
    logic collision_selftest_sel_n = 1'b1;
    logic full_duplex_sel_n = 1'b1;
    logic driver_en, tx_line_data, rx_en_out, rx_data_out;
    logic collision_status, jabber_status, link_status, full_duplex_active;
    int n_errors = 0;
    int tests_run = 0;
    int n;

    mac_model i_mac_model (.clk(clk), .rst_n(rst_n), .send(send),
        .toggle(toggle), .tx_en(tx_en), .tx_data(tx_data));

    twisted_pair_status_mode_ctl #(.JAB_TRIP(TRIP), .JAB_QUIET(QUIET),
        .LINK_TOG(TOG), .COLL_HOLD(HOLD), .SQE_WIN(WIN))
    i_twisted_pair_status_mode_ctl (.clk(clk), .rst_n(rst_n),
        .tx_en(tx_en), .tx_data(tx_data), .rx_unsquelch(rx_unsquelch),
        .rx_data(rx_data), .link_fail(link_fail), .loop_sel_n(loop_sel_n),
        .collision_selftest_sel_n(collision_selftest_sel_n),
        .full_duplex_sel_n(full_duplex_sel_n), .driver_en(driver_en),
        .tx_line_data(tx_line_data), .rx_en_out(rx_en_out),
        .rx_data_out(rx_data_out), .collision_status(collision_status),
        .jabber_status(jabber_status), .link_status(link_status),
        .full_duplex_active(full_duplex_active));

    initial begin
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function automatic logic outv(input int sel);
        case (sel)
            0: outv = collision_status;
            1: outv = jabber_status;
            default: outv = link_status;
        endcase
    endfunction

    // Counts cycles until the chosen status reaches v, bounded by lim
    task automatic wait_for(input int sel, input logic v, input int lim,
                            output int cnt);
        cnt = 0;
        while (outv(sel) !== v && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        tick(19);
        check(jabber_status, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        #1;
        check(jabber_status, 1'b0);
        check(collision_status, 1'b0);
        check(link_status, 1'b1);
        tick(4);
    endtask

    task automatic t_loopback;
        @(posedge clk) send <= 1'b1;
        tick(6);
        check(rx_en_out, 1'b1);
        check(driver_en, 1'b1);
        check(rx_data_out, tx_data);
        @(posedge clk) toggle <= 1'b1;
        @(posedge clk) toggle <= 1'b0;
        tick(6);
        check(rx_data_out, tx_data);
        check(tx_line_data, 1'b1);
        check(collision_status, 1'b0);
        @(posedge clk) send <= 1'b0;
        tick(6);
        check(rx_en_out, 1'b0);
    endtask

    task automatic t_collision;
        @(posedge clk) begin
            send <= 1'b1;
            rx_unsquelch <= 1'b1;
        end
        wait_for(0, 1'b1, 8, n);
        check(collision_status, 1'b1);
        check(jabber_status, 1'b0);
        check(driver_en, 1'b1);
        @(posedge clk) begin
            send <= 1'b0;
            rx_unsquelch <= 1'b0;
        end
        wait_for(0, 1'b0, HOLD + 10, n);
        check(n >= HOLD && n <= HOLD + 4, 1'b1);
    endtask

    task automatic t_selftest;
        @(posedge clk) begin
            collision_selftest_sel_n <= 1'b0;
            send <= 1'b1;
            toggle <= 1'b1;
        end
        tick(10);
        check(collision_status, 1'b0);
        check(driver_en, 1'b1);
        check(rx_en_out, 1'b1);
        @(posedge clk) send <= 1'b0;
        wait_for(0, 1'b1, 8, n);
        check(collision_status, 1'b1);
        wait_for(0, 1'b0, WIN + 4, n);
        check(n == WIN, 1'b1);
        check(jabber_status, 1'b0);
        @(posedge clk) toggle <= 1'b0;
    endtask

    task automatic t_full_duplex;
        @(posedge clk) full_duplex_sel_n <= 1'b0;
        tick(5);
        check(full_duplex_active, 1'b1);
        @(posedge clk) begin
            send <= 1'b1;
            rx_unsquelch <= 1'b1;
        end
        tick(8);
        check(collision_status, 1'b0);
        check(driver_en, 1'b1);
        check(rx_en_out, 1'b1);
        @(posedge clk) rx_unsquelch <= 1'b0;
        tick(5);
        check(rx_en_out, 1'b0);
        @(posedge clk) send <= 1'b0;
        wait_for(0, 1'b1, 8, n);
        check(collision_status, 1'b1);
        wait_for(0, 1'b0, WIN + 4, n);
        @(posedge clk) begin
            full_duplex_sel_n <= 1'b1;
            collision_selftest_sel_n <= 1'b1;
        end
        tick(5);
        check(full_duplex_active, 1'b0);
    endtask

    task automatic t_loop_test;
        @(posedge clk) begin
            loop_sel_n <= 1'b0;
            send <= 1'b1;
            rx_unsquelch <= 1'b1;
            rx_data <= 1'b1;
        end
        tick(8);
        check(collision_status, 1'b0);
        check(rx_en_out, 1'b1);
        check(rx_data_out, tx_data);
        @(posedge clk) send <= 1'b0;
        tick(6);
        check(rx_en_out, 1'b0);
        @(posedge clk) begin
            loop_sel_n <= 1'b1;
            rx_unsquelch <= 1'b0;
        end
        tick(HOLD + 6);
    endtask

    task automatic t_jabber;
        @(posedge clk) begin
            send <= 1'b1;
            toggle <= 1'b1;
        end
        wait_for(1, 1'b1, TRIP + 10, n);
        check(n >= TRIP && n <= TRIP + 6, 1'b1);
        check(collision_status, 1'b1);
        check(driver_en, 1'b0);
        check(tx_line_data, 1'b0);
        check(rx_en_out, 1'b0);
        tick(QUIET + 10);
        check(jabber_status, 1'b1);
        @(posedge clk) toggle <= 1'b0;
        wait_for(1, 1'b0, QUIET + 10, n);
        check(n >= QUIET && n <= QUIET + 6, 1'b1);
        @(posedge clk) send <= 1'b0;
        tick(2);
        check(collision_status, 1'b0);
    endtask

    task automatic t_link;
        @(posedge clk) link_fail <= 1'b1;
        tick(5);
        check(link_status, 1'b0);
        @(posedge clk) link_fail <= 1'b0;
        tick(5);
        check(link_status, 1'b1);
        @(posedge clk) begin
            rx_unsquelch <= 1'b1;
            rx_data <= 1'b1;
        end
        wait_for(2, 1'b0, TOG + 10, n);
        check(rx_data_out, 1'b1);
        wait_for(2, 1'b1, TOG + 4, n);
        check(n == TOG, 1'b1);
        wait_for(2, 1'b0, TOG + 4, n);
        check(n == TOG, 1'b1);
        @(posedge clk) rx_unsquelch <= 1'b0;
        tick(5);
        check(link_status, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        t_reset();
        t_loopback();
        t_collision();
        t_selftest();
        t_full_duplex();
        t_loop_test();
        t_jabber();
        t_link();
        report_and_stop();
    end

    initial begin
        #200_000;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
